// ---- ext_clock_src.sv ----
// Model of an external clock source on the timer count pins.
// Assumes the bench owns the run control and the clock.
`timescale 1ns/100ps
module ext_clock_src #(
    parameter int HALF = 3
)(
    // Clock
    input wire logic clk_i,
    // Control
    input wire logic run_i,
    // Pin and edge counts
    output logic pin_o,
    output int rises_o,
    output int falls_o
);
    int cnt = 0;
    logic pin = 1'b0;
    int rises = 0;
    int falls = 0;

    // ------------------------------
    // Pin toggling
    // ------------------------------
    // Quiet start: the pin idles low
    assign pin_o = pin;
    assign rises_o = rises;
    assign falls_o = falls;

    // Toggle every HALF cycles; level held when stopped
    always @(posedge clk_i)
    begin
        if (run_i && cnt == HALF - 1)
        begin
            pin <= !pin;
            rises <= rises + !pin;
            falls <= falls + pin;
        end
        cnt <= (run_i && cnt < HALF - 1) ? cnt + 1 : 0;
    end
endmodule : ext_clock_src

// ---- pin_edge_detect.sv ----
// Synchroniser and edge detector for the external count pins.
// Assumes pins change no faster than half the clock rate.
`timescale 1ns/100ps
module pin_edge_detect
    import timer_prescaler_pkg::*;
#(
    parameter int PINS = 2
)(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Raw pins
    input wire logic [PINS-1:0] pin_i,
    // Edges out
    tick_path_if.edges path
);

    if (PINS < 1)
        $error("pin_edge_detect: PINS must be at least one");

    logic [PINS-1:0] meta_reg;
    logic [PINS-1:0] sync_reg;
    logic [PINS-1:0] prev_reg;

    // Sample each pin once per clock; first stage feeds only the second
    for (genvar p = 0; p < PINS; p++)
    begin : g_pin
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                meta_reg[p] <= 1'b0;
                sync_reg[p] <= 1'b0;
                prev_reg[p] <= 1'b0;
            end
            else
            begin
                meta_reg[p] <= pin_i[p];
                sync_reg[p] <= meta_reg[p];
                prev_reg[p] <= sync_reg[p];
            end
        end

        // One pulse per detected edge
        always_comb
        begin
            path.pin_rise[p] = sync_reg[p] & ~prev_reg[p];
            path.pin_fall[p] = ~sync_reg[p] & prev_reg[p];
            path.pin_level[p] = sync_reg[p];
        end
    end

endmodule : pin_edge_detect

// ---- shared_divider.sv ----
// Free-running divider giving one-cycle taps at /8, /64, /256, /1024.
// Assumes the clear input is a synchronous level from the top.
`timescale 1ns/100ps
module shared_divider
    import timer_prescaler_pkg::*;
#(
    parameter int WIDTH = 10
)(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Taps and clear
    tick_path_if.divider path
);
`include "timer_prescaler_consts.svh"

    // Taps below need all of the widest tap's bits
    if (WIDTH < `TAP_DIV1024_BITS)
        $error("shared_divider: WIDTH too small for the /1024 tap");

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // Counter runs regardless of any tick source choice
    always_comb
    begin
        count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
        if (path.divider_clear)
            count_next = '0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count_reg <= '0;
        else
            count_reg <= count_next;
    end

    // Taps fire on the last count of each period; silent while cleared
    always_comb
    begin
        path.tap[0] = &count_reg[`TAP_DIV8_BITS-1:0];
        path.tap[1] = &count_reg[`TAP_DIV64_BITS-1:0];
        path.tap[2] = &count_reg[`TAP_DIV256_BITS-1:0];
        path.tap[3] = &count_reg[`TAP_DIV1024_BITS-1:0];
        if (path.divider_clear)
            path.tap = 4'h0;
    end

endmodule : shared_divider

// ---- shared_timer_prescaler_ext_clock_tb.sv ----
// Self-checking bench for the shared timer prescaler top.
// Assumes the checker is bound in and the pin model drives both pins.
`timescale 1ns/100ps
`include "timer_prescaler_consts.svh"
module shared_timer_prescaler_ext_clock_tb
    import timer_prescaler_pkg::*;
;
    localparam logic [7:0] CTL = `OFS_GENERAL_TIMER_CONTROL;
    localparam logic [7:0] SEL = `OFS_TICK_SOURCE_SELECT;
    localparam logic [7:0] IRQ = `OFS_TIMER0_IRQ;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic ext_pin;
    logic timer0_overflow_i = 1'b0;
    logic overflow_vector_taken_i = 1'b0;
    logic timer_zero_tick_o;
    logic timer_one_tick_o;
    logic async_divider_reset_o;
    logic timer0_overflow_irq_o;
    logic run = 1'b0;
    int rises;
    int falls;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;

    timer_prescaler_top dut (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .count_pin_zero_i(ext_pin),
        .count_pin_one_i(ext_pin), .timer0_overflow_i,
        .overflow_vector_taken_i, .timer_zero_tick_o, .timer_one_tick_o,
        .async_divider_reset_o, .timer0_overflow_irq_o
    );
    ext_clock_src #(.HALF(3)) src (.clk_i, .run_i(run), .pin_o(ext_pin),
        .rises_o(rises), .falls_o(falls));

    // 125 MHz clock
    always #4 clk_i = !clk_i;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    // Classic cycle; ack and data are taken at the same edge
    task automatic bus(input logic [7:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1)
            @(posedge clk_i);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input string nm);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        check(nm, q, e);
    endtask : rd

    // Cycles until the chosen timer ticks, bounded
    task automatic wait_tick(input bit one, output int t);
        t = 0;
        do
        begin
            @(posedge clk_i);
            t++;
        end
        while ((one ? timer_one_tick_o : timer_zero_tick_o) !== 1'b1
            && t < 3000);
    endtask : wait_tick

    task automatic count(input int n, inout int c0, inout int c1);
        repeat (n)
        begin
            @(posedge clk_i);
            c0 += (timer_zero_tick_o === 1'b1);
            c1 += (timer_one_tick_o === 1'b1);
        end
    endtask : count

    task automatic pulse(input bit ovf);
        timer0_overflow_i <= ovf;
        overflow_vector_taken_i <= !ovf;
        @(posedge clk_i);
        timer0_overflow_i <= 1'b0;
        overflow_vector_taken_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : pulse

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        rd(CTL, 32'h0, "control reset");
        rd(SEL, 32'h0, "select reset");
        wr(8'h10, 32'hFF);
        rd(8'h10, 32'h0, "unmapped");
    endtask : t_regs

    task automatic t_direct;
        int c0 = 0;
        int c1 = 0;
        wr(SEL, 32'h01);
        count(16, c0, c1);
        check("direct ticks", c0, 16);
        check("stopped ticks", c1, 0);
    endtask : t_direct

    task automatic t_taps;
        int n[4] = '{8, 64, 256, 1024};
        int t;
        for (int i = 0; i < 4; i++)
        begin
            wr(SEL, ((i + 2) << 4) | 2);
            wait_tick(1'b1, t);
            check("first tick", t <= n[i] + 1, 1);
            wait_tick(1'b1, t);
            check("tap period", t, n[i]);
        end
        wait_tick(1'b0, t);
        wait_tick(1'b0, t);
        check("shared period", t, 8);
    endtask : t_taps

    // Two resets at different phases must give the same first tick
    task automatic t_reset;
        int ta;
        int tb;
        wr(SEL, 32'h33);
        wr(CTL, 32'h01);
        wait_tick(1'b1, ta);
        repeat (37) @(posedge clk_i);
        wr(CTL, 32'h01);
        wait_tick(1'b1, tb);
        check("restart", tb, ta);
        check("both timers", timer_zero_tick_o, 1'b1);
        rd(CTL, 32'h0, "self clear");
    endtask : t_reset

    task automatic t_hold;
        int c0 = 0;
        int c1 = 0;
        int t;
        wr(CTL, 32'h83);
        rd(CTL, 32'h83, "hold bits");
        check("async held", async_divider_reset_o, 1'b1);
        count(200, c0, c1);
        check("held ticks", c0 + c1, 0);
        wr(CTL, 32'h0);
        rd(CTL, 32'h0, "released");
        wait_tick(1'b1, t);
        check("resume", t <= 65, 1);
    endtask : t_hold

    // Select is changed only while the pin is still
    task automatic t_pins;
        int c0 = 0;
        int c1 = 0;
        wr(SEL, 32'h67);
        run <= 1'b1;
        count(120, c0, c1);
        run <= 1'b0;
        count(8, c0, c1);
        check("rise ticks", c0, rises);
        check("fall ticks", c1, falls);
        rd(`OFS_STATUS, ext_pin ? 32'h3 : 32'h0, "pin levels");
    endtask : t_pins

    task automatic t_irq;
        wr(IRQ, 32'h06);
        pulse(1'b1);
        check("irq raised", timer0_overflow_irq_o, 1'b1);
        rd(IRQ, 32'h07, "flag set");
        wr(IRQ, 32'h07);
        check("write clear", timer0_overflow_irq_o, 1'b0);
        pulse(1'b1);
        pulse(1'b0);
        check("vector clear", timer0_overflow_irq_o, 1'b0);
        pulse(1'b1);
        wr(IRQ, 32'h02);
        check("masked", timer0_overflow_irq_o, 1'b0);
        rd(IRQ, 32'h03, "flag kept");
    endtask : t_irq

    task automatic wrap_up;
        if (n_mismatch == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // Hang guard, far above the few thousand cycles needed
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_direct();
        t_taps();
        t_reset();
        t_hold();
        t_pins();
        t_irq();
        wrap_up();
    end
endmodule : shared_timer_prescaler_ext_clock_tb

// ---- tick_path_if.sv ----
// Carrier between the top, the shared divider and the pin edge detector.
// Assumes all parties run on one clock.
`timescale 1ns/100ps
interface tick_path_if #(parameter int PINS = 2);
    logic divider_clear;
    logic [3:0] tap;
    logic [PINS-1:0] pin_rise;
    logic [PINS-1:0] pin_fall;
    logic [PINS-1:0] pin_level;

    // Divider side
    modport divider (input divider_clear, output tap);
    // Edge detector side
    modport edges (output pin_rise, output pin_fall, output pin_level);
    // Consumer side
    modport user (output divider_clear, input tap, input pin_rise,
        input pin_fall, input pin_level);
endinterface : tick_path_if

// ---- timer_prescaler_chk.sv ----
// Checker for the shared timer prescaler, bound to the top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`include "timer_prescaler_consts.svh"
module timer_prescaler_chk
    import timer_prescaler_pkg::*;
#(
    parameter int DIVIDER_WIDTH = 10,
    parameter int TIMERS = 2
)(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Pins and events
    input wire logic count_pin_zero_i,
    input wire logic count_pin_one_i,
    input wire logic timer0_overflow_i,
    input wire logic overflow_vector_taken_i,
    // Ticks and control
    input wire logic timer_zero_tick_o,
    input wire logic timer_one_tick_o,
    input wire logic async_divider_reset_o,
    input wire logic timer0_overflow_irq_o
);
    logic wr;
    logic wr_ctl;
    logic wr_sel;
    logic wr_irq;
    logic [6:0] sel_reg;

    // Byte 0 writes, taken only while the slave is idle
    assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    assign wr_ctl = wr && adr_i == `OFS_GENERAL_TIMER_CONTROL;
    assign wr_sel = wr && adr_i == `OFS_TICK_SOURCE_SELECT;
    assign wr_irq = wr && adr_i == `OFS_TIMER0_IRQ;

    // Shadow of both selects, same edge as the real register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sel_reg <= 7'h00;
        else if (wr_sel)
            sel_reg <= dat_i[6:0];
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    irq_rise_cause_a: assert property ($rose(timer0_overflow_irq_o) |->
        $past(timer0_overflow_i) || $past(wr_irq))
        else $error("irq rose without cause");
    irq_fall_cause_a: assert property ($fell(timer0_overflow_irq_o) &&
        !$past(rst_i) |-> $past(overflow_vector_taken_i) || $past(wr_irq))
        else $error("irq fell without cause");
    direct_tick_a: assert property (sel_reg[2:0] == SRC_DIRECT &&
        $past(sel_reg[2:0]) == SRC_DIRECT |-> timer_zero_tick_o)
        else $error("direct source missed a tick");
    pin_rise_tick_a: assert property ($rose(count_pin_zero_i) &&
        sel_reg[2:0] == SRC_PIN_RISE |-> ##3 timer_zero_tick_o)
        else $error("rising pin tick late or missing");
    pin_fall_tick_a: assert property ($fell(count_pin_one_i) &&
        sel_reg[6:4] == SRC_PIN_FALL |-> ##3 timer_one_tick_o)
        else $error("falling pin tick late or missing");
    div8_gap_a: assert property (timer_one_tick_o &&
        sel_reg[6:4] == SRC_DIV8 |=> !timer_one_tick_o [*7])
        else $error("divide by 8 ticks too close");
    sync_reset_quiet_a: assert property (wr_ctl && dat_i[0] &&
        sel_reg[6:4] >= SRC_DIV8 && sel_reg[6:4] <= SRC_DIV1024
        |=> ##1 !timer_one_tick_o [*6])
        else $error("tick soon after divider reset");
    hold_keep_a: assert property (wr_ctl && dat_i[7] && dat_i[1]
        |=> async_divider_reset_o [*3])
        else $error("held async reset dropped");
    hold_clear_a: assert property (wr_ctl && !dat_i[7]
        |=> ##1 !async_divider_reset_o)
        else $error("async reset not cleared");
endmodule : timer_prescaler_chk

bind timer_prescaler_top timer_prescaler_chk #(
    .DIVIDER_WIDTH(DIVIDER_WIDTH),
    .TIMERS(TIMERS)
) chk (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .count_pin_zero_i, .count_pin_one_i,
    .timer0_overflow_i, .overflow_vector_taken_i, .timer_zero_tick_o,
    .timer_one_tick_o, .async_divider_reset_o, .timer0_overflow_irq_o
);

// ---- timer_prescaler_consts.svh ----
// Constants for the shared timer prescaler: register offsets, fields,
// reset values and divider taps. Definitions only, no logic.
`ifndef TIMER_PRESCALER_CONSTS_SVH
`define TIMER_PRESCALER_CONSTS_SVH

// ------------------------------
// Register byte offsets
// ------------------------------
`define OFS_GENERAL_TIMER_CONTROL 8'h00
`define OFS_TICK_SOURCE_SELECT 8'h04
`define OFS_TIMER0_IRQ 8'h08
`define OFS_STATUS 8'h0C

// ------------------------------
// Field positions and reset values
// ------------------------------
`define BIT_SYNC_HOLD_MODE 7
`define BIT_ASYNC_DIVIDER_RESET 1
`define BIT_SYNC_DIVIDER_RESET 0
`define FLD_SELECT0_LSB 0
`define FLD_SELECT1_LSB 4
`define BIT_OVERFLOW_FLAG 0
`define BIT_OVERFLOW_IRQ_ENABLE 1
`define BIT_GLOBAL_IRQ_ENABLE 2
`define RST_GENERAL_TIMER_CONTROL 8'h00
`define RST_TICK_SOURCE_SELECT 6'h00

// ------------------------------
// Divider taps: low counter bits that must all be one
// ------------------------------
`define TAP_DIV8_BITS 3
`define TAP_DIV64_BITS 6
`define TAP_DIV256_BITS 8
`define TAP_DIV1024_BITS 10

`endif

// ---- timer_prescaler_pkg.sv ----
// Types shared by the prescaler, edge detector and top.
// Assumes the constants header is included where offsets are needed.
package timer_prescaler_pkg;

    // Tick source choices of one timer
    typedef enum logic [2:0] {
        SRC_STOP = 3'h0,
        SRC_DIRECT = 3'h1,
        SRC_DIV8 = 3'h2,
        SRC_DIV64 = 3'h3,
        SRC_DIV256 = 3'h4,
        SRC_DIV1024 = 3'h5,
        SRC_PIN_FALL = 3'h6,
        SRC_PIN_RISE = 3'h7
    } tick_source_type;

    // Bus slave handshake states
    typedef enum logic [0:0] {
        BUS_IDLE = 1'h0,
        BUS_ACK = 1'h1
    } bus_state_type;

endpackage : timer_prescaler_pkg

// ---- timer_prescaler_top.sv ----
// Shared timer prescaler with external count pins and a Wishbone slave.
// Assumes a classic Wishbone master on clk_i and pins synchronous-ish.
//
// Notes on behaviour
// R1: Overflow flag sets on overflow; cleared by vector or writing one.
// R2: Overflow request only while global enable, overflow enable, flag set.
// R3: Source select 1 ticks the timer every clock cycle while the sync divider reset bit is clear.
// R4: Divider offers taps at /8, /64, /256, /1024, selectable per timer.
// R5: Divider runs freely, shared, each timer has its own select.
// R6: First prescaled tick comes 1 to N+1 cycles after enabling.
// R7: Divider reset restarts the period for both timers.
// R8: Count pin sampled every clock, synchronised, then edge detected.
// R9: Select 7 ticks on rising pin edge, select 6 on falling.
// R10: Pin edge reaches the tick output a few cycles later.
// R11: Software switches pin sources only with the pin stable one cycle.
// R12: External clock half periods must exceed one clock cycle.
// R13: Pin ticks bypass the divider; no division applies to them.
// R14: With hold mode set, written divider reset bits stay asserted.
// R15: Writing hold mode zero clears both divider reset bits.
// R16: Sync divider reset bit resets divider, self-clears unless held.
// R17: Select 0 gives no tick; the timer stays stopped.
// R18: Async divider reset self-clears likewise and is held in hold mode.
`timescale 1ns/100ps
module timer_prescaler_top
    import timer_prescaler_pkg::*;
#(
    parameter int DIVIDER_WIDTH = 10,
    parameter int TIMERS = 2
)(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // External count pins
    input wire logic count_pin_zero_i,
    input wire logic count_pin_one_i,
    // Timer 0 overflow events
    input wire logic timer0_overflow_i,
    input wire logic overflow_vector_taken_i,
    // Tick and control outputs
    output logic timer_zero_tick_o,
    output logic timer_one_tick_o,
    output logic async_divider_reset_o,
    output logic timer0_overflow_irq_o
);
`include "timer_prescaler_consts.svh"

    // ------------------------------
    // Elaboration checks
    // ------------------------------
    // Two select fields and two pins are laid out in the registers
    if (TIMERS != 2)
        $error("timer_prescaler_top: register layout serves two timers");

    // ------------------------------
    // Sub-blocks
    // ------------------------------
    tick_path_if #(.PINS(TIMERS)) path ();

    shared_divider #(
        .WIDTH(DIVIDER_WIDTH)
    ) u_divider (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .path(path.divider)
    );

    pin_edge_detect #(
        .PINS(TIMERS)
    ) u_edges (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({count_pin_one_i, count_pin_zero_i}),
        .path(path.edges)
    );

    // ------------------------------
    // State
    // ------------------------------
    bus_state_type bus_reg;
    bus_state_type bus_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic hold_reg;
    logic hold_next;
    logic async_rst_reg;
    logic async_rst_next;
    logic sync_rst_reg;
    logic sync_rst_next;
    tick_source_type select_reg [TIMERS];
    tick_source_type select_next [TIMERS];
    logic flag_reg;
    logic flag_next;
    logic ovf_en_reg;
    logic ovf_en_next;
    logic gie_reg;
    logic gie_next;
    logic irq_reg;
    logic irq_next;
    logic [TIMERS-1:0] tick_reg;
    logic [TIMERS-1:0] tick_next;

    logic access;
    logic wr_low;

    // ------------------------------
    // Bus decode
    // ------------------------------
    // Request taken once; ack then drops for a cycle
    always_comb
    begin
        access = cyc_i & stb_i & (bus_reg == BUS_IDLE);
        wr_low = access & we_i & sel_i[0];
    end

    // ------------------------------
    // Bus handshake and read data
    // ------------------------------
    // Unmapped offsets still ack, reading zero
    always_comb
    begin
        bus_next = BUS_IDLE;
        rdata_next = rdata_reg;
        if (access)
        begin
            bus_next = BUS_ACK;
            rdata_next = 32'h0000_0000;
            case (adr_i)
                `OFS_GENERAL_TIMER_CONTROL:
                begin
                    rdata_next[`BIT_SYNC_HOLD_MODE] = hold_reg;
                    rdata_next[`BIT_ASYNC_DIVIDER_RESET] = async_rst_reg;
                    rdata_next[`BIT_SYNC_DIVIDER_RESET] = sync_rst_reg;
                end
                `OFS_TICK_SOURCE_SELECT:
                begin
                    rdata_next[`FLD_SELECT0_LSB +: 3] = select_reg[0];
                    rdata_next[`FLD_SELECT1_LSB +: 3] = select_reg[1];
                end
                `OFS_TIMER0_IRQ:
                begin
                    rdata_next[`BIT_OVERFLOW_FLAG] = flag_reg;
                    rdata_next[`BIT_OVERFLOW_IRQ_ENABLE] = ovf_en_reg;
                    rdata_next[`BIT_GLOBAL_IRQ_ENABLE] = gie_reg;
                end
                `OFS_STATUS:
                begin
                    rdata_next[1:0] = path.pin_level;
                    rdata_next[5:4] = tick_reg;
                end
                default:
                begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bus_reg <= BUS_IDLE;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            bus_reg <= bus_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------
    // General timer control: hold mode and divider resets
    // ------------------------------
    // Reset bits self-clear one cycle after any write unless held
    always_comb
    begin
        hold_next = hold_reg;
        async_rst_next = async_rst_reg;
        sync_rst_next = sync_rst_reg;
        if (!hold_reg)
        begin
            async_rst_next = 1'b0; // R18
            sync_rst_next = 1'b0; // R15
        end
        if (wr_low && adr_i == `OFS_GENERAL_TIMER_CONTROL)
        begin
            hold_next = dat_i[`BIT_SYNC_HOLD_MODE];
            // A written one always lasts at least one cycle
            async_rst_next = dat_i[`BIT_ASYNC_DIVIDER_RESET]; // R14
            sync_rst_next = dat_i[`BIT_SYNC_DIVIDER_RESET]; // R16
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hold_reg <= 1'b0;
            async_rst_reg <= 1'b0;
            sync_rst_reg <= 1'b0;
        end
        else
        begin
            hold_reg <= hold_next;
            async_rst_reg <= async_rst_next;
            sync_rst_reg <= sync_rst_next;
        end
    end

    // One clear for the shared divider serves both timers
    assign path.divider_clear = sync_rst_reg; // R7

    // ------------------------------
    // Tick source selects
    // ------------------------------
    always_comb
    begin
        select_next = select_reg;
        if (wr_low && adr_i == `OFS_TICK_SOURCE_SELECT)
        begin
            select_next[0] = tick_source_type'(dat_i[`FLD_SELECT0_LSB +: 3]);
            select_next[1] = tick_source_type'(dat_i[`FLD_SELECT1_LSB +: 3]);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            select_reg[0] <= SRC_STOP;
            select_reg[1] <= SRC_STOP;
        end
        else
        begin
            select_reg <= select_next;
        end
    end

    // ------------------------------
    // Per-timer tick selection
    // ------------------------------
    // Each timer reads the same taps; the divider never sees the selects
    for (genvar t = 0; t < TIMERS; t++)
    begin : g_tick
        always_comb
        begin
            case (select_reg[t])
                SRC_STOP: tick_next[t] = 1'b0; // R17
                SRC_DIRECT: tick_next[t] = 1'b1; // R3
                SRC_DIV8: tick_next[t] = path.tap[0]; // R4
                SRC_DIV64: tick_next[t] = path.tap[1]; // R4
                SRC_DIV256: tick_next[t] = path.tap[2]; // R4
                SRC_DIV1024: tick_next[t] = path.tap[3]; // R5 R6
                SRC_PIN_FALL: tick_next[t] = path.pin_fall[t]; // R9 R13
                SRC_PIN_RISE: tick_next[t] = path.pin_rise[t]; // R9 R13
                default: tick_next[t] = 1'b0;
            endcase
            // Held divider halts every prescaled timer
            if (sync_rst_reg && select_reg[t] != SRC_PIN_FALL
                && select_reg[t] != SRC_PIN_RISE
                && select_reg[t] != SRC_STOP)
                tick_next[t] = 1'b0; // R14
        end
    end

    // Registered ticks; pin path adds sync, detect and this stage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tick_reg <= '0;
        else
            tick_reg <= tick_next; // R8 R10
    end

    // ------------------------------
    // Timer 0 overflow flag and interrupt request
    // ------------------------------
    // A new overflow in the clearing cycle wins, so none is lost
    always_comb
    begin
        flag_next = flag_reg;
        ovf_en_next = ovf_en_reg;
        gie_next = gie_reg;
        if (overflow_vector_taken_i)
            flag_next = 1'b0; // R1
        if (wr_low && adr_i == `OFS_TIMER0_IRQ)
        begin
            if (dat_i[`BIT_OVERFLOW_FLAG])
                flag_next = 1'b0; // R1
            ovf_en_next = dat_i[`BIT_OVERFLOW_IRQ_ENABLE];
            gie_next = dat_i[`BIT_GLOBAL_IRQ_ENABLE];
        end
        if (timer0_overflow_i)
            flag_next = 1'b1; // R1
        irq_next = gie_next & ovf_en_next & flag_next; // R2
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flag_reg <= 1'b0;
            ovf_en_reg <= 1'b0;
            gie_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            flag_reg <= flag_next;
            ovf_en_reg <= ovf_en_next;
            gie_reg <= gie_next;
            irq_reg <= irq_next;
        end
    end

    // ------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------
    always_comb
    begin
        dat_o = rdata_reg;
        ack_o = (bus_reg == BUS_ACK);
        timer_zero_tick_o = tick_reg[0];
        timer_one_tick_o = tick_reg[1];
        async_divider_reset_o = async_rst_reg;
        timer0_overflow_irq_o = irq_reg;
    end

endmodule : timer_prescaler_top
